// ==== dss_map.svh ====
// Register offsets, field positions, selection codes and reset values of the
// drive status output block. Definitions only; included by the terminal selector and the top module.
`ifndef DSS_MAP_SVH
`define DSS_MAP_SVH

// Register byte offsets
`define DSS_OFF_CTRL      8'h00
`define DSS_OFF_HS_LEVEL  8'h04
`define DSS_OFF_UC_LEVEL  8'h08
`define DSS_OFF_SEL_LO    8'h0c
`define DSS_OFF_SEL_HI    8'h10
`define DSS_OFF_STATUS    8'h14
`define DSS_OFF_INT_STAT  8'h18
`define DSS_OFF_INT_MASK  8'h1c

// Control register fields
`define DSS_CTRL_SRC_BIT  0
`define DSS_CTRL_MODE_LSB 2
`define DSS_CTRL_OPF_BIT  4
`define DSS_CTRL_OPR_BIT  5

// Undercurrent mode values
`define DSS_UC_MODE_RUN   2'h0
`define DSS_UC_MODE_CONST 2'h1

// Selection codes
`define DSS_CODE_START_T  6'h2c
`define DSS_CODE_START_R  6'h29
`define DSS_CODE_HEAT     6'h2a
`define DSS_CODE_LOWCUR   6'h2b
`define DSS_CODE_READY    6'h32
`define DSS_CODE_FWD      6'h33
`define DSS_CODE_REV      6'h34
`define DSS_CODE_MAJOR    6'h35

// Limits and reset values
`define DSS_HS_MAX        8'hc8
`define DSS_HS_RST        8'h78
`define DSS_UC_RST        12'h000
`define DSS_SEL_RST       6'h3f
`define DSS_EVT_W         5

`endif

// ==== dss_pkg.sv ====
// Types shared by the drive status output modules.
// Assumes nothing beyond a SystemVerilog compiler.
package dss_pkg;
    // Drive direction state
    typedef enum logic [1:0] {DRV_STOP, DRV_FWD, DRV_REV} dss_drive_t;

    // One bit per status flag
    typedef struct packed {
        logic major;
        logic rev;
        logic fwd;
        logic ready;
        logic lowcur;
        logic heat;
        logic start;
    } dss_flags_t;
endpackage

// ==== dss_flag_if.sv ====
// Interface carrying the evaluated status flags to the terminal selectors.
// Assumes one producer (the top) and any number of selector instances.
`timescale 1ns/1ps
interface dss_flag_if;
    dss_pkg::dss_flags_t flags;
    modport src (output flags);
    modport mux (input  flags);
endinterface

// ==== dss_term_mux.sv ====
// One output terminal selector: picks the flag that its code names.
// Assumes the code is a stable register value on the same clock.
`timescale 1ns/1ps
`include "dss_map.svh"
module dss_term_mux #(
    parameter bit IS_RELAY = 1'b0
) (
    // Flags in
    dss_flag_if.mux   fif,
    // Selection and result
    input  wire logic [5:0] sel_in,
    output logic            q_out
);
    // Relay offers the start flag under its own code; unknown codes read low
    always_comb begin
        q_out = 1'b0;
        case (sel_in)
            `DSS_CODE_START_T: q_out = IS_RELAY ? 1'b0 : fif.flags.start;
            `DSS_CODE_START_R: q_out = IS_RELAY ? fif.flags.start : 1'b0;
            `DSS_CODE_HEAT:    q_out = fif.flags.heat;
            `DSS_CODE_LOWCUR:  q_out = fif.flags.lowcur;
            `DSS_CODE_READY:   q_out = fif.flags.ready;
            `DSS_CODE_FWD:     q_out = fif.flags.fwd;
            `DSS_CODE_REV:     q_out = fif.flags.rev;
            `DSS_CODE_MAJOR:   q_out = fif.flags.major;
            default:           q_out = 1'b0;
        endcase
    end
endmodule // dss_term_mux

// ==== dss_status_top.sv ====
// Drive status output generator: evaluates the status flags, decides the
// drive direction and routes the flags to five terminals and the relay.
// Assumes the temperature, current, trip and speed inputs come from logic on
// MCLK_IN; only the terminal run commands are pins and get synchronised.
`timescale 1ns/1ps
`include "dss_map.svh"
module dss_status_top #(
    parameter int RATED_CURRENT = 400
) (
    // Clock and reset
    input  wire logic        MCLK_IN,
    input  wire logic        SRST_IN,
    // Register port
    input  wire logic [7:0]  ADDR_IN,
    input  wire logic [31:0] WDATA_IN,
    input  wire logic        WR_IN,
    input  wire logic        RD_IN,
    output logic      [31:0] RDATA_OUT,
    // Run command pins
    input  wire logic        FWD_PIN_IN,
    input  wire logic        REV_PIN_IN,
    // Internal drive state
    input  wire logic        MAIN_POWER_OK_IN,
    input  wire logic        TRIP_IN,
    input  wire logic [5:0]  HW_TRIP_CAUSE_IN,
    input  wire logic [7:0]  HEATSINK_TEMP_IN,
    input  wire logic [11:0] OUT_CURRENT_IN,
    input  wire logic        CONST_SPEED_IN,
    // Drive and terminals
    output logic             DRIVE_FWD_OUT,
    output logic             DRIVE_REV_OUT,
    output logic [4:0]       TERM_OUT,
    output logic             RELAY_OUT,
    output logic             ALARM_OUT,
    output logic             IRQ_OUT
);
    localparam int UC_MAX_INT = (RATED_CURRENT * 3) / 2;
    localparam logic [11:0] UC_MAX = 12'(UC_MAX_INT);

    // Refuse a rated current whose limit does not fit the level field
    if (RATED_CURRENT < 1 || UC_MAX_INT > 4095) begin : g_chk
        $error("RATED_CURRENT out of range");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic fwd_meta_r, fwd_sync_r, rev_meta_r, rev_sync_r;
    logic fwd_meta_nxt, fwd_sync_nxt, rev_meta_nxt, rev_sync_nxt;

    // First stage is read only by the second stage
    always_comb begin
        fwd_meta_nxt = FWD_PIN_IN;
        fwd_sync_nxt = fwd_meta_r;
        rev_meta_nxt = REV_PIN_IN;
        rev_sync_nxt = rev_meta_r;
    end

    always_ff @(posedge MCLK_IN) begin
        if (SRST_IN) begin
            fwd_meta_r <= 1'b0;
            fwd_sync_r <= 1'b0;
            rev_meta_r <= 1'b0;
            rev_sync_r <= 1'b0;
        end else begin
            fwd_meta_r <= fwd_meta_nxt;
            fwd_sync_r <= fwd_sync_nxt;
            rev_meta_r <= rev_meta_nxt;
            rev_sync_r <= rev_sync_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register file

    logic                         run_src_r, run_src_nxt;
    logic [1:0]                   uc_mode_r, uc_mode_nxt;
    logic                         op_fwd_r, op_fwd_nxt;
    logic                         op_rev_r, op_rev_nxt;
    logic [7:0]                   hs_level_r, hs_level_nxt;
    logic [11:0]                  uc_level_r, uc_level_nxt;
    logic [5:0]                   sel_r [6];
    logic [5:0]                   sel_nxt [6];
    logic [`DSS_EVT_W-1:0]        int_stat_r, int_stat_nxt;
    logic [`DSS_EVT_W-1:0]        int_mask_r, int_mask_nxt;
    logic [31:0]                  rdata_nxt;
    logic [`DSS_EVT_W-1:0]        evt;
    dss_pkg::dss_drive_t          drive_r;
    dss_pkg::dss_flags_t          flags_r;

    // Writes clamp the limits; status events win over a same-cycle clear
    always_comb begin
        run_src_nxt  = run_src_r;
        uc_mode_nxt  = uc_mode_r;
        op_fwd_nxt   = op_fwd_r;
        op_rev_nxt   = op_rev_r;
        hs_level_nxt = hs_level_r;
        uc_level_nxt = uc_level_r;
        sel_nxt      = sel_r;
        int_mask_nxt = int_mask_r;
        int_stat_nxt = int_stat_r;
        if (WR_IN) begin
            unique case (ADDR_IN)
                `DSS_OFF_CTRL: begin
                    run_src_nxt = WDATA_IN[`DSS_CTRL_SRC_BIT];
                    uc_mode_nxt = WDATA_IN[`DSS_CTRL_MODE_LSB +: 2];
                    op_fwd_nxt  = WDATA_IN[`DSS_CTRL_OPF_BIT];
                    op_rev_nxt  = WDATA_IN[`DSS_CTRL_OPR_BIT];
                end
                `DSS_OFF_HS_LEVEL: begin
                    hs_level_nxt = (WDATA_IN[7:0] > `DSS_HS_MAX) ? `DSS_HS_MAX
                                                                : WDATA_IN[7:0];
                end
                `DSS_OFF_UC_LEVEL: begin
                    uc_level_nxt = (WDATA_IN[11:0] > UC_MAX) ? UC_MAX
                                                             : WDATA_IN[11:0];
                end
                `DSS_OFF_SEL_LO: begin
                    for (int i = 0; i < 4; i++) begin
                        sel_nxt[i] = WDATA_IN[i*8 +: 6];
                    end
                end
                `DSS_OFF_SEL_HI: begin
                    sel_nxt[4] = WDATA_IN[5:0];
                    sel_nxt[5] = WDATA_IN[13:8];
                end
                `DSS_OFF_INT_STAT: int_stat_nxt = int_stat_r & ~WDATA_IN[`DSS_EVT_W-1:0];
                `DSS_OFF_INT_MASK: int_mask_nxt = WDATA_IN[`DSS_EVT_W-1:0];
                default: ;
            endcase
        end
        int_stat_nxt = int_stat_nxt | evt;
        // Read data stand for the one cycle after the strobe
        rdata_nxt = 32'h0;
        if (RD_IN) begin
            unique case (ADDR_IN)
                `DSS_OFF_CTRL:     rdata_nxt = {26'h0, op_rev_r, op_fwd_r, uc_mode_r,
                                                1'b0, run_src_r};
                `DSS_OFF_HS_LEVEL: rdata_nxt = {24'h0, hs_level_r};
                `DSS_OFF_UC_LEVEL: rdata_nxt = {20'h0, uc_level_r};
                `DSS_OFF_SEL_LO:   rdata_nxt = {2'h0, sel_r[3], 2'h0, sel_r[2],
                                                2'h0, sel_r[1], 2'h0, sel_r[0]};
                `DSS_OFF_SEL_HI:   rdata_nxt = {18'h0, sel_r[5], 2'h0, sel_r[4]};
                `DSS_OFF_STATUS:   rdata_nxt = {22'h0, drive_r, 1'b0, flags_r};
                `DSS_OFF_INT_STAT: rdata_nxt = {27'h0, int_stat_r};
                `DSS_OFF_INT_MASK: rdata_nxt = {27'h0, int_mask_r};
                default:           rdata_nxt = 32'h0;
            endcase
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (SRST_IN) begin
            run_src_r  <= 1'b0;
            uc_mode_r  <= `DSS_UC_MODE_RUN;
            op_fwd_r   <= 1'b0;
            op_rev_r   <= 1'b0;
            hs_level_r <= `DSS_HS_RST;
            uc_level_r <= `DSS_UC_RST;
            for (int i = 0; i < 6; i++) begin
                sel_r[i] <= `DSS_SEL_RST;
            end
            int_stat_r <= '0;
            int_mask_r <= '0;
            RDATA_OUT  <= 32'h0;
        end else begin
            run_src_r  <= run_src_nxt;
            uc_mode_r  <= uc_mode_nxt;
            op_fwd_r   <= op_fwd_nxt;
            op_rev_r   <= op_rev_nxt;
            hs_level_r <= hs_level_nxt;
            uc_level_r <= uc_level_nxt;
            sel_r      <= sel_nxt;
            int_stat_r <= int_stat_nxt;
            int_mask_r <= int_mask_nxt;
            RDATA_OUT  <= rdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Drive direction and flag evaluation

    logic                cmd_fwd, cmd_rev, cmd_any, ready_c, running;
    logic                blocked_r, blocked_nxt;
    dss_pkg::dss_drive_t drive_nxt;
    dss_pkg::dss_flags_t flags_c;
    logic [4:0]          term_c;
    logic                relay_c;
    logic                alarm_nxt, irq_nxt;
    logic [4:0]          term_nxt;
    logic                relay_nxt;

    dss_flag_if fif ();

    // Commands seen from the configured source only drive the motor
    always_comb begin
        cmd_fwd = run_src_r ? op_fwd_r : fwd_sync_r;
        cmd_rev = run_src_r ? op_rev_r : rev_sync_r;
        cmd_any = fwd_sync_r | rev_sync_r | op_fwd_r | op_rev_r;
        ready_c = MAIN_POWER_OK_IN & ~TRIP_IN;
        running = (drive_r != dss_pkg::DRV_STOP);
    end

    // A command raised while not ready stays locked out until released
    always_comb begin
        blocked_nxt = (cmd_fwd | cmd_rev) &
                      (blocked_r | (~ready_c & ~running));
        drive_nxt   = dss_pkg::DRV_STOP;
        if (!ready_c || blocked_r) begin
            drive_nxt = dss_pkg::DRV_STOP;
        end else if (cmd_fwd && cmd_rev) begin
            drive_nxt = dss_pkg::DRV_STOP;
        end else if (cmd_fwd) begin
            drive_nxt = dss_pkg::DRV_FWD;
        end else if (cmd_rev) begin
            drive_nxt = dss_pkg::DRV_REV;
        end
    end

    // Flags are combinational so they drop in the cycle their cause ends
    always_comb begin
        flags_c.start  = cmd_any;
        flags_c.heat   = HEATSINK_TEMP_IN > hs_level_r;
        flags_c.lowcur = (OUT_CURRENT_IN <= uc_level_r) & running &
                         ((uc_mode_r != `DSS_UC_MODE_CONST) | CONST_SPEED_IN);
        flags_c.ready  = ready_c;
        flags_c.fwd    = drive_r == dss_pkg::DRV_FWD;
        flags_c.rev    = drive_r == dss_pkg::DRV_REV;
        flags_c.major  = TRIP_IN & (|HW_TRIP_CAUSE_IN);
        fif.flags      = flags_c;
    end

    // One selector per terminal; the last one is the relay
    for (genvar g = 0; g < 5; g++) begin : g_term
        dss_term_mux #(.IS_RELAY(1'b0)) u_mux (
            .fif    (fif.mux),
            .sel_in (sel_r[g]),
            .q_out  (term_c[g])
        );
    end

    dss_term_mux #(.IS_RELAY(1'b1)) u_relay (
        .fif    (fif.mux),
        .sel_in (sel_r[5]),
        .q_out  (relay_c)
    );

    // Events: major fault, heat warning, low current, ready lost, command refused
    always_comb begin
        evt[0]    = flags_c.major & ~flags_r.major;
        evt[1]    = flags_c.heat & ~flags_r.heat;
        evt[2]    = flags_c.lowcur & ~flags_r.lowcur;
        evt[3]    = ~flags_c.ready & flags_r.ready;
        evt[4]    = blocked_nxt & ~blocked_r;
        term_nxt  = term_c;
        relay_nxt = relay_c;
        alarm_nxt = TRIP_IN;
        irq_nxt   = |(int_stat_nxt & int_mask_nxt);
    end

    always_ff @(posedge MCLK_IN) begin
        if (SRST_IN) begin
            blocked_r     <= 1'b0;
            drive_r       <= dss_pkg::DRV_STOP;
            flags_r       <= '0;
            TERM_OUT      <= 5'h00;
            RELAY_OUT     <= 1'b0;
            ALARM_OUT     <= 1'b0;
            IRQ_OUT       <= 1'b0;
            DRIVE_FWD_OUT <= 1'b0;
            DRIVE_REV_OUT <= 1'b0;
        end else begin
            blocked_r     <= blocked_nxt;
            drive_r       <= drive_nxt;
            flags_r       <= flags_c;
            TERM_OUT      <= term_nxt;
            RELAY_OUT     <= relay_nxt;
            ALARM_OUT     <= alarm_nxt;
            IRQ_OUT       <= irq_nxt;
            DRIVE_FWD_OUT <= drive_nxt == dss_pkg::DRV_FWD;
            DRIVE_REV_OUT <= drive_nxt == dss_pkg::DRV_REV;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (SRST_IN);

    property p_start_follows;
        (fwd_sync_r | rev_sync_r | op_fwd_r | op_rev_r) == 1'b1 |=> flags_r.start;
    endproperty
    a_start_follows: assert property (p_start_follows) else $error("start flag missing");

    property p_start_any_source;
        run_src_r && (fwd_sync_r || rev_sync_r) |=> flags_r.start;
    endproperty
    a_start_any_source: assert property (p_start_any_source) else $error("source gated start");

    property p_both_stop;
        cmd_fwd && cmd_rev |=> !DRIVE_FWD_OUT && !DRIVE_REV_OUT;
    endproperty
    a_both_stop: assert property (p_both_stop) else $error("drive with both commands");

    property p_heat;
        HEATSINK_TEMP_IN > hs_level_r |=> flags_r.heat;
    endproperty
    a_heat: assert property (p_heat) else $error("heat warning missing");

    property p_hs_limit;
        hs_level_r <= `DSS_HS_MAX;
    endproperty
    a_hs_limit: assert property (p_hs_limit) else $error("heat level above limit");

    property p_lowcur_const;
        uc_mode_r == `DSS_UC_MODE_CONST && !CONST_SPEED_IN |=> !flags_r.lowcur;
    endproperty
    a_lowcur_const: assert property (p_lowcur_const) else $error("low current off speed");

    property p_lowcur_run;
        running && uc_mode_r == `DSS_UC_MODE_RUN && OUT_CURRENT_IN <= uc_level_r
            |=> flags_r.lowcur;
    endproperty
    a_lowcur_run: assert property (p_lowcur_run) else $error("low current missing");

    property p_uc_limit;
        uc_level_r <= UC_MAX;
    endproperty
    a_uc_limit: assert property (p_uc_limit) else $error("current level above limit");

    property p_no_power;
        !MAIN_POWER_OK_IN |=> !flags_r.ready ##0 !DRIVE_FWD_OUT && !DRIVE_REV_OUT;
    endproperty
    a_no_power: assert property (p_no_power) else $error("ready without power");

    property p_refused;
        !ready_c && !running && cmd_fwd && !cmd_rev ##1 ready_c && cmd_fwd && !cmd_rev
            |=> !DRIVE_FWD_OUT;
    endproperty
    a_refused: assert property (p_refused) else $error("early command obeyed");

    property p_dir_flags;
        DRIVE_FWD_OUT |=> flags_r.fwd && !flags_r.rev;
    endproperty
    a_dir_flags: assert property (p_dir_flags) else $error("direction flag wrong");

    property p_rev_flag;
        DRIVE_REV_OUT |=> flags_r.rev && !flags_r.fwd;
    endproperty
    a_rev_flag: assert property (p_rev_flag) else $error("reverse flag wrong");

    property p_major;
        TRIP_IN && HW_TRIP_CAUSE_IN != 6'h00 |=> flags_r.major && ALARM_OUT;
    endproperty
    a_major: assert property (p_major) else $error("major flag missing");

    property p_major_only_hw;
        HW_TRIP_CAUSE_IN == 6'h00 |=> !flags_r.major;
    endproperty
    a_major_only_hw: assert property (p_major_only_hw) else $error("major without cause");

    property p_term_route;
        sel_r[3] == `DSS_CODE_READY |=> TERM_OUT[3] == flags_r.ready;
    endproperty
    a_term_route: assert property (p_term_route) else $error("terminal routing wrong");

    property p_relay_start;
        sel_r[5] == `DSS_CODE_START_R && $stable(sel_r[5]) |=> RELAY_OUT == flags_r.start;
    endproperty
    a_relay_start: assert property (p_relay_start) else $error("relay start wrong");

    property p_drop;
        !cmd_any && sel_r[0] == `DSS_CODE_START_T |=> !flags_r.start && !TERM_OUT[0];
    endproperty
    a_drop: assert property (p_drop) else $error("flag held too long");
endmodule // dss_status_top

// ==== dss_ext_ctrl.sv ====
// External controller model: closes the run command contacts on request.
// Assumes one clock shared with the design; pins change just after an edge.
`timescale 1ns/1ps
module dss_ext_ctrl (
    // Clock
    input  wire logic       clk_in,
    // Requests, bit 0 forward and bit 1 reverse
    input  wire logic [1:0] cmd_in,
    // Run command pins
    output logic            fwd_pin_out = 1'b0,
    output logic            rev_pin_out = 1'b0
);
    ////////////////////////////////////////////////////////////
    // Contacts start open, so no command is seen during reset
    // Contacts follow the request one edge later, like a relay
    always @(posedge clk_in) begin
        fwd_pin_out <= cmd_in[0];
        rev_pin_out <= cmd_in[1];
    end
endmodule // dss_ext_ctrl

// ==== dss_status_top_tb.sv ====
// Testbench for the drive status block: register tasks and flag scenarios.
// Assumes the design files and the controller model are compiled first.
`timescale 1ns/1ps
module dss_status_top_tb;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [31:0] rdata;
    logic [1:0]  cmd = 2'h0;
    logic        fwd_pin;
    logic        rev_pin;
    logic        pwr = 1'b0;
    logic        trip = 1'b0;
    logic [5:0]  cause = 6'h00;
    logic [7:0]  temp = 8'h00;
    logic [11:0] cur = 12'hfff;
    logic        cspd = 1'b0;
    logic        dfwd;
    logic        drev;
    logic [4:0]  term;
    logic        relay;
    logic        alarm;
    logic        irq;
    int          fail_count = 0;
    int          tests_run = 0;
    ////////////////////////////////////////////////////////////
    // 40 MHz clock
    always #12.5 clk = ~clk;
    dss_ext_ctrl ctl_u (.clk_in(clk), .cmd_in(cmd), .fwd_pin_out(fwd_pin), .rev_pin_out(rev_pin));
    dss_status_top #(.RATED_CURRENT(400)) dut_u (
        .MCLK_IN(clk), .SRST_IN(srst), .ADDR_IN(addr), .WDATA_IN(wdata),
        .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .FWD_PIN_IN(fwd_pin),
        .REV_PIN_IN(rev_pin), .MAIN_POWER_OK_IN(pwr), .TRIP_IN(trip),
        .HW_TRIP_CAUSE_IN(cause), .HEATSINK_TEMP_IN(temp), .OUT_CURRENT_IN(cur),
        .CONST_SPEED_IN(cspd), .DRIVE_FWD_OUT(dfwd), .DRIVE_REV_OUT(drev),
        .TERM_OUT(term), .RELAY_OUT(relay), .ALARM_OUT(alarm), .IRQ_OUT(irq));
    ////////////////////////////////////////////////////////////
    // Compare and count
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    // One-cycle write; the strobe drops at the next edge
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // One-cycle read; data is looked at in the single cycle it stands
    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(nm, e, rdata);
    endtask
    // Let n edges pass, then step off the edge before sampling
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic lc_case(input logic [31:0] ctrl, input logic cs, input logic e);
        wr_reg(8'h00, ctrl);
        cspd <= cs;
        wait_cyc(3);
        chk("lowcur_mode", {31'h0, e}, {31'h0, term[2]});
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Watchdog: a hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        finish_test;
    end
    ////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        rd_chk("hs_rst", 8'h04, 32'h78);
        rd_chk("sel_rst", 8'h0c, 32'h3f3f3f3f);
        rd_chk("unmapped", 8'h20, 32'h0);
        wr_reg(8'h04, 32'hff);
        rd_chk("hs_clamp", 8'h04, 32'hc8);
        wr_reg(8'h08, 32'hfff);
        rd_chk("uc_clamp", 8'h08, 32'h258);
        // Terminals: start, heat, lowcur, ready, fwd; relay start
        wr_reg(8'h0c, 32'h322b2a2c);
        wr_reg(8'h10, 32'h2933);
        wr_reg(8'h1c, 32'h1f);
        @(posedge clk);
        pwr <= 1'b1;
        wait_cyc(3);
        chk("ready_term", 32'h08, {27'h0, term});
        @(posedge clk);
        cmd <= 2'h1;
        wait_cyc(6);
        chk("fwd_term", 32'h19, {27'h0, term});
        chk("fwd_relay", 32'h3, {30'h0, relay, dfwd});
        rd_chk("stat_fwd", 8'h14, 32'h119);
        @(posedge clk);
        cmd <= 2'h3;
        wait_cyc(6);
        rd_chk("stat_both", 8'h14, 32'h009);
        chk("both_drive", 32'h0, {30'h0, drev, dfwd});
        @(posedge clk);
        cmd <= 2'h2;
        wait_cyc(6);
        rd_chk("stat_rev", 8'h14, 32'h229);
        // Reverse code on terminal 4; the terminal start code on the relay reads low
        wr_reg(8'h10, 32'h2c34);
        wait_cyc(2);
        chk("rev_term", 32'h1, {30'h0, relay, term[4]});
        // Current exactly at the level counts, one above does not
        @(posedge clk);
        cur <= 12'h258;
        wait_cyc(2);
        chk("lowcur_eq", 32'h1, {31'h0, term[2]});
        @(posedge clk);
        cur <= 12'h259;
        wait_cyc(2);
        chk("lowcur_above", 32'h0, {31'h0, term[2]});
        @(posedge clk);
        cur <= 12'h258;
        lc_case(32'h4, 1'b0, 1'b0);
        lc_case(32'h4, 1'b1, 1'b1);
        lc_case(32'hc, 1'b0, 1'b1);
        lc_case(32'h0, 1'b0, 1'b1);
        @(posedge clk);
        temp <= 8'hc8;
        wait_cyc(2);
        chk("heat_eq", 32'h0, {31'h0, term[1]});
        @(posedge clk);
        temp <= 8'hc9;
        wait_cyc(2);
        chk("heat_above", 32'h1, {31'h0, term[1]});
        @(posedge clk);
        temp <= 8'h00;
        // Register source: the held pin still shows as start, drive stops
        wr_reg(8'h00, 32'h01);
        wait_cyc(3);
        chk("src_reg_stop", 32'h09, {26'h0, drev, term});
        @(posedge clk);
        cmd <= 2'h0;
        wr_reg(8'h00, 32'h11);
        wait_cyc(6);
        chk("src_reg_fwd", 32'h3, {30'h0, term[0], dfwd});
        // Power loss with the command held: stop, then stay locked out
        @(posedge clk);
        pwr <= 1'b0;
        wait_cyc(3);
        chk("nopower", 32'h0, {30'h0, term[3], dfwd});
        @(posedge clk);
        pwr <= 1'b1;
        wait_cyc(3);
        chk("locked", 32'h2, {30'h0, term[3], dfwd});
        rd_chk("int_stat", 8'h18, 32'h1e);
        chk("irq_on", 32'h1, {31'h0, irq});
        wr_reg(8'h1c, 32'h0);
        wait_cyc(2);
        chk("irq_masked", 32'h0, {31'h0, irq});
        wr_reg(8'h18, 32'h1e);
        rd_chk("int_clr", 8'h18, 32'h0);
        wr_reg(8'h00, 32'h01);
        wr_reg(8'h00, 32'h11);
        wait_cyc(4);
        chk("relocked_run", 32'h1, {31'h0, dfwd});
        // Major code on terminal 4; each cause in turn, then no cause
        wr_reg(8'h10, 32'h2935);
        for (int i = 0; i < 7; i++) begin
            @(posedge clk);
            trip <= 1'b1;
            cause <= (i < 6) ? (6'h01 << i) : 6'h00;
            wait_cyc(2);
            chk("alarm", 32'h1, {31'h0, alarm});
            chk("major", {31'h0, (i < 6)}, {31'h0, term[4]});
        end
        @(posedge clk);
        trip <= 1'b0;
        cause <= 6'h3f;
        wait_cyc(2);
        chk("major_drop", 32'h0, {30'h0, alarm, term[4]});
        finish_test;
    end
endmodule // dss_status_top_tb
